// file: bench/flash_dev_model.sv
`timescale 1ns/10ps
module flash_dev_model
  import flash_seq_pkg::*;
(
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_out,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_ce_n,
  input wire logic flash_reset_n,
  output logic [DATA_W-1:0] flash_dq_in,
  output logic flash_ready_busy_n
);
  int busy = 0;
  logic chip = 1'b0, tg = 1'b0, junk = 1'b0;
  // Released bus keeps changing so a late sample never sees stale data.
  always #4 begin
    junk = ~junk;
    if (busy > 0) busy--;
  end
  always @(negedge flash_oe_n) tg = ~tg;
  always @(negedge flash_reset_n) busy = 0;
  always @(posedge flash_we_n) begin
    if (!flash_ce_n && flash_reset_n && !(chip && busy > 0)) begin
      chip = (flash_dq_out == CMD_CHIP_ERASE);
      case (flash_dq_out)
        CMD_CHIP_ERASE: busy = 750;
        CMD_SECTOR_ERASE: busy = 600;
        CMD_SUSPEND, CMD_RESET: busy = 0;
        CMD_PW_PROGRAM: busy = 100;
        default: ;
      endcase
    end
  end
  assign flash_dq_in = (!flash_oe_n && !flash_ce_n) ? (busy > 0 ? {9'h000, tg, 6'h00} : 16'hFFFF) : {16{junk}};
  assign flash_ready_busy_n = (busy == 0);
endmodule

// file: bench/flash_erase_and_password_sequencer_tb.sv
`timescale 1ns/10ps
module flash_erase_and_password_sequencer_tb
  import flash_seq_pkg::*;
;
  logic sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [REG_ADDR_W-1:0] reg_addr = 8'h00;
  logic [REG_DATA_W-1:0] reg_wdata = 32'h0, reg_rdata, st;
  logic [ADDR_W-1:0] flash_addr;
  logic [DATA_W-1:0] flash_dq_in, flash_dq_out;
  logic flash_dq_oe, flash_we_n, flash_oe_n, flash_ce_n, flash_reset_n, flash_ready_busy_n;
  int error_cnt = 0, checked = 0, wes = 0;
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge flash_we_n) if (reset_n) wes++;
  flash_erase_host #(.ACCUM_CYCLES(400), .SUSPEND_CYCLES(200)) dut_u (.sys_clk, .reset_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe,
    .flash_we_n, .flash_oe_n, .flash_ce_n, .flash_reset_n, .flash_ready_busy_n);
  flash_dev_model dev_u (.flash_addr, .flash_dq_out, .flash_we_n, .flash_oe_n, .flash_ce_n,
    .flash_reset_n, .flash_dq_in, .flash_ready_busy_n);
  task automatic print_verdict();
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 st = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic wait_b(input int b, input logic v);
    int n = 2000;
    rd(REG_STATUS);
    while (st[b] !== v && n > 0) begin
      rd(REG_STATUS);
      n--;
    end
    if (n == 0) begin
      error_cnt++;
      $display("ERROR %0t status wait timeout", $time);
      print_verdict();
    end
  endtask
  task automatic t_chip();
    wes = 0;
    wr(REG_CMD, OP_CHIP_ERASE);
    wait_b(ST_ERASING, 1);
    chk(wes, 6);
    wr(REG_CMD, OP_SUSPEND);
    rd(REG_STATUS);
    chk({st[ST_REFUSED], st[ST_SUSPENDED]}, 2'b10);
    wait_b(ST_ERASING, 0);
    chk({st[ST_READY], wes[3:0]}, 5'h16);
    wr(REG_CMD, OP_READ);
    wait_b(ST_BUSY, 0);
    rd(REG_RDATA);
    chk(st, 32'h0000FFFF);
    wr(REG_STATUS, 1 << ST_REFUSED);
  endtask
  task automatic t_sector();
    wes = 0;
    wr(REG_ADDR, 32'h010000);
    wr(REG_CMD, OP_SECTOR_ERASE);
    wait_b(ST_ACCUM, 1);
    wr(REG_CMD, OP_ADD_SECTOR);
    wait_b(ST_BUSY, 0);
    wr(REG_CMD, OP_SUSPEND);
    wait_b(ST_BUSY, 0);
    chk(st[3:1], 3'b100);
    wr(REG_CMD, OP_RESUME);
    wait_b(ST_BUSY, 0);
    wr(REG_CMD, OP_RESUME);
    rd(REG_STATUS);
    chk({st[ST_TIMER_EXPIRED], st[ST_REFUSED], st[ST_SUSPENDED], wes[3:0]}, 7'h69);
    wr(REG_CMD, OP_SUSPEND);
    wait_b(ST_BUSY, 0);
    repeat (101) rd(REG_STATUS);
    chk(st[3:2], 2'b10);
    wr(REG_CMD, OP_RESET_CMD);
    wait_b(ST_BUSY, 0);
    chk(st[3:2], 2'b10);
    wr(REG_CMD, OP_RESUME);
    wait_b(ST_READY, 1);
    wait_b(ST_ERASING, 0);
    wr(REG_STATUS, 1 << ST_REFUSED);
  endtask
  task automatic t_abort();
    wr(REG_CMD, OP_SECTOR_ERASE);
    wait_b(ST_TIMER_EXPIRED, 1);
    chk(st[2:1], 2'b10);
    wait_b(ST_ERASING, 0);
    wr(REG_CMD, OP_SECTOR_ERASE);
    wait_b(ST_ACCUM, 1);
    wr(REG_CMD, OP_RESET_CMD);
    wait_b(ST_BUSY, 0);
    chk(st[2:1], 2'b00);
    wr(REG_CMD, OP_CHIP_ERASE);
    wait_b(ST_ERASING, 1);
    wr(REG_RESET, 1);
    rd(REG_STATUS);
    chk({flash_reset_n, st[ST_ABORTED], st[ST_ERASING]}, 3'b010);
    wr(REG_RESET, 0);
    wr(REG_STATUS, 1 << ST_ABORTED);
    wait_b(ST_READY, 1);
    chk(st[ST_ABORTED], 0);
  endtask
  task automatic t_pw();
    wes = 0;
    for (int i = 0; i < 4; i++) begin
      wr(REG_ADDR, i);
      wr(REG_DATA, 32'h1230 + i);
      wr(REG_CMD, OP_PW_PROGRAM);
      wait_b(ST_BUSY, 0);
      wait_b(ST_PW_BUSY, 0);
      wait_b(ST_BUSY, 0);
    end
    chk(wes, 20);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_chip();
    t_sector();
    t_abort();
    t_pw();
    print_verdict();
  end
endmodule

// file: rtl/flash_bus_cycle.sv
`timescale 1ns/10ps
module flash_bus_cycle
  import flash_seq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic write_en,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [DATA_W-1:0] dq_sync,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_ce_n
);

  eng_state_t state, next_state;
  logic [COUNT_W-1:0] count, next_count, limit;
  logic is_write, next_is_write;
  logic next_done, next_dq_oe, next_we_n, next_oe_n, next_ce_n;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_dq_out, next_rdata;

  // Reads hold the output enable long enough to cover the pin synchroniser.
  assign limit = is_write ? COUNT_W'(WE_LOW_CYCLES) : COUNT_W'(RD_ACCESS_CYCLES + SYNC_STAGES);

  always_comb begin
    next_state = state;
    next_count = count;
    next_is_write = is_write;
    next_done = 1'b0;
    next_dq_oe = flash_dq_oe;
    next_we_n = flash_we_n;
    next_oe_n = flash_oe_n;
    next_ce_n = flash_ce_n;
    next_addr = flash_addr;
    next_dq_out = flash_dq_out;
    next_rdata = rdata;
    unique case (state)
      E_IDLE: begin
        if (start) begin
          next_is_write = write_en;
          next_addr = addr_in;
          next_dq_out = data_in;
          next_dq_oe = write_en;
          next_ce_n = 1'b0;
          next_state = E_SETUP;
        end
      end
      E_SETUP: begin
        next_we_n = !is_write;
        next_oe_n = is_write;
        next_count = '0;
        next_state = E_PULSE;
      end
      E_PULSE: begin
        next_count = count + COUNT_W'(1);
        if (count == limit - COUNT_W'(1)) begin
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
          if (!is_write) begin
            next_rdata = dq_sync;
          end
          next_state = E_HOLD;
        end
      end
      E_HOLD: begin
        next_ce_n = 1'b1;
        next_dq_oe = 1'b0;
        next_done = 1'b1;
        next_state = E_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= E_IDLE;
      count <= '0;
      is_write <= 1'b0;
      done <= 1'b0;
      flash_dq_oe <= 1'b0;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_addr <= '0;
      flash_dq_out <= '0;
      rdata <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
      is_write <= next_is_write;
      done <= next_done;
      flash_dq_oe <= next_dq_oe;
      flash_we_n <= next_we_n;
      flash_oe_n <= next_oe_n;
      flash_ce_n <= next_ce_n;
      flash_addr <= next_addr;
      flash_dq_out <= next_dq_out;
      rdata <= next_rdata;
    end
  end

endmodule

// file: rtl/flash_erase_host.sv
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// What this block does
// - Chip erase: six writes ending chip command
// - Hardware reset aborts erase; reissue later
// - Sector erase: six writes ending sector address
// - Keep added sector gaps under 80 us
// - Other command in window aborts to read
// - Resume at suspended bank; repeats ignored
// - Password as four unlocked 38h portions
// - Password programming needs reset command after
module flash_erase_host
  import flash_seq_pkg::*;
#(
  parameter int unsigned ACCUM_CYCLES = ACCUM_WINDOW_CYCLES,
  parameter int unsigned SUSPEND_CYCLES = SUSPEND_MAX_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_DATA_W-1:0] reg_rdata,
  output logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_ce_n,
  output logic flash_reset_n,
  input wire logic flash_ready_busy_n
);

  logic [DATA_W:0] pins_sync;
  logic [DATA_W-1:0] dq_sync, eng_rdata, eng_data;
  logic ready, eng_start, eng_done, cmd_go, accept, refuse_pulse, abort_pulse;
  logic [ADDR_W-1:0] eng_addr;

  logic [ADDR_W-1:0] addr_reg, next_addr_reg, cmd_addr, next_cmd_addr, susp_bank, next_susp_bank;
  logic [DATA_W-1:0] data_reg, next_data_reg, cmd_data, next_cmd_data, read_word, next_read_word;
  logic [REG_DATA_W-1:0] next_reg_rdata, status_word;
  logic reset_ctrl, next_reset_ctrl, refused, next_refused, aborted, next_aborted;
  logic [OPCODE_W-1:0] kind, next_kind, op;
  logic [2:0] step, next_step;
  logic [TIMER_W-1:0] timer, next_timer;
  seq_state_t seq, next_seq;
  mode_t mode, next_mode;

  pin_sync #(.WIDTH(DATA_W + 1)) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .din({flash_ready_busy_n, flash_dq_in}),
    .dout(pins_sync)
  );
  assign dq_sync = pins_sync[DATA_W-1:0];
  assign ready = pins_sync[DATA_W];

  flash_bus_cycle u_cycle (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(eng_start),
    .write_en(kind != OP_READ),
    .addr_in(eng_addr),
    .data_in(eng_data),
    .dq_sync(dq_sync),
    .done(eng_done),
    .rdata(eng_rdata),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n),
    .flash_ce_n(flash_ce_n)
  );

  assign flash_reset_n = !reset_ctrl;
  assign cmd_go = reg_wr && (reg_addr == REG_CMD);
  assign op = reg_wdata[OPCODE_W-1:0];

  function automatic logic [2:0] last_step(input logic [OPCODE_W-1:0] k);
    if (k == OP_CHIP_ERASE || k == OP_SECTOR_ERASE) begin
      return 3'h5;
    end else if (k == OP_PW_PROGRAM) begin
      return 3'h3;
    end
    return 3'h0;
  endfunction

  // Host side of the command rules: nothing is sent that the device would ignore or that
  // would silently cancel the queued sector erase.
  function automatic logic allowed(input logic [OPCODE_W-1:0] o, input mode_t m, input logic [TIMER_W-1:0] t);
    if (o == OP_READ) begin
      return 1'b1;
    end
    unique case (m)
      M_IDLE: return o == OP_CHIP_ERASE || o == OP_SECTOR_ERASE || o == OP_PW_PROGRAM || o == OP_RESET_CMD;
      M_ACCUM: return o == OP_SUSPEND ||
        ((o == OP_ADD_SECTOR || o == OP_RESET_CMD) && 32'(t) + 32'(ADD_GUARD_CYCLES) < 32'(ACCUM_CYCLES));
      M_SECTOR: return o == OP_SUSPEND;
      M_SUSPENDED: return o == OP_RESUME || o == OP_RESET_CMD;
      M_CHIP, M_SUSPENDING, M_PW: return 1'b0;
    endcase
  endfunction

  always_comb begin
    eng_addr = cmd_addr;
    eng_data = cmd_data;
    unique case (step)
      3'h0: begin
        if (last_step(kind) != 3'h0) begin
          eng_addr = UNLOCK_ADDR1;
          eng_data = UNLOCK_DATA1;
        end else if (kind == OP_ADD_SECTOR) begin
          eng_data = CMD_SECTOR_ERASE;
        end else if (kind == OP_SUSPEND) begin
          eng_data = CMD_SUSPEND;
        end else if (kind == OP_RESUME) begin
          eng_addr = susp_bank;
          eng_data = CMD_RESUME;
        end else begin
          eng_data = CMD_RESET;
        end
      end
      3'h1, 3'h4: begin
        eng_addr = UNLOCK_ADDR2;
        eng_data = UNLOCK_DATA2;
      end
      3'h2: begin
        eng_addr = UNLOCK_ADDR1;
        eng_data = (kind == OP_PW_PROGRAM) ? CMD_PW_PROGRAM : CMD_ERASE_SETUP;
      end
      3'h3: begin
        if (kind != OP_PW_PROGRAM) begin
          eng_addr = UNLOCK_ADDR1;
          eng_data = UNLOCK_DATA1;
        end
      end
      3'h5: begin
        if (kind == OP_CHIP_ERASE) begin
          eng_addr = UNLOCK_ADDR1;
          eng_data = CMD_CHIP_ERASE;
        end else begin
          eng_data = CMD_SECTOR_ERASE;
        end
      end
      default: begin
        eng_addr = cmd_addr;
        eng_data = cmd_data;
      end
    endcase
  end

  always_comb begin
    next_seq = seq;
    next_mode = mode;
    next_kind = kind;
    next_step = step;
    next_timer = timer;
    next_cmd_addr = cmd_addr;
    next_cmd_data = cmd_data;
    next_susp_bank = susp_bank;
    next_read_word = read_word;
    eng_start = 1'b0;
    accept = 1'b0;
    refuse_pulse = 1'b0;
    abort_pulse = 1'b0;
    unique case (mode)
      M_ACCUM: begin
        next_timer = timer + TIMER_W'(1);
        if (32'(timer) + 32'd1 >= 32'(ACCUM_CYCLES)) begin
          next_mode = M_SECTOR;
          next_timer = '0;
        end
      end
      M_CHIP, M_SECTOR: begin
        if (32'(timer) < 32'(BUSY_SETTLE_CYCLES)) begin
          next_timer = timer + TIMER_W'(1);
        end else if (ready) begin
          next_mode = M_IDLE;
        end
      end
      M_SUSPENDING: begin
        next_timer = timer + TIMER_W'(1);
        if ((32'(timer) >= 32'(BUSY_SETTLE_CYCLES) && ready) || 32'(timer) + 32'd1 >= 32'(SUSPEND_CYCLES)) begin
          next_mode = M_SUSPENDED;
        end
      end
      M_PW: begin
        if (32'(timer) < 32'(BUSY_SETTLE_CYCLES)) begin
          next_timer = timer + TIMER_W'(1);
        end
      end
      M_IDLE, M_SUSPENDED: begin
        next_timer = timer;
      end
    endcase
    unique case (seq)
      S_IDLE: begin
        if (mode == M_PW && 32'(timer) >= 32'(BUSY_SETTLE_CYCLES) && ready) begin
          // Programming the password leaves every read returning status until reset is written.
          next_kind = OP_RESET_CMD;
          next_step = '0;
          next_seq = S_ISSUE;
          next_mode = M_IDLE;
        end else if (cmd_go) begin
          if (allowed(op, mode, timer) && !reset_ctrl) begin
            accept = 1'b1;
            next_kind = op;
            next_step = '0;
            next_cmd_addr = addr_reg;
            next_cmd_data = data_reg;
            next_seq = S_ISSUE;
          end else begin
            refuse_pulse = 1'b1;
          end
        end
      end
      S_ISSUE: begin
        eng_start = 1'b1;
        next_seq = S_WAIT;
        if (cmd_go) begin
          refuse_pulse = 1'b1;
        end
      end
      S_WAIT: begin
        if (cmd_go) begin
          refuse_pulse = 1'b1;
        end
        if (eng_done) begin
          if (step == last_step(kind)) begin
            next_seq = S_IDLE;
            next_timer = '0;
            if (kind == OP_CHIP_ERASE) begin
              next_mode = M_CHIP;
            end else if (kind == OP_SECTOR_ERASE || kind == OP_ADD_SECTOR) begin
              next_mode = M_ACCUM;
            end else if (kind == OP_SUSPEND) begin
              next_susp_bank = cmd_addr;
              next_mode = (mode == M_ACCUM) ? M_SUSPENDED : M_SUSPENDING;
            end else if (kind == OP_RESUME) begin
              next_mode = M_SECTOR;
            end else if (kind == OP_RESET_CMD) begin
              next_mode = (mode == M_SUSPENDED) ? M_SUSPENDED : M_IDLE;
            end else if (kind == OP_PW_PROGRAM) begin
              next_mode = M_PW;
            end else begin
              next_read_word = eng_rdata;
              next_timer = timer;
            end
          end else begin
            next_step = step + 3'h1;
            next_seq = S_ISSUE;
          end
        end
      end
    endcase
    if (reset_ctrl) begin
      // Holding the device in reset kills any erase; software must start over once it is released.
      abort_pulse = (mode != M_IDLE) && (mode != M_PW);
      next_mode = M_IDLE;
      next_timer = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq <= S_IDLE;
      mode <= M_IDLE;
      kind <= OP_NONE;
      step <= '0;
      timer <= '0;
      cmd_addr <= '0;
      cmd_data <= '0;
      susp_bank <= '0;
      read_word <= '0;
    end else begin
      seq <= next_seq;
      mode <= next_mode;
      kind <= next_kind;
      step <= next_step;
      timer <= next_timer;
      cmd_addr <= next_cmd_addr;
      cmd_data <= next_cmd_data;
      susp_bank <= next_susp_bank;
      read_word <= next_read_word;
    end
  end

  always_comb begin
    status_word = '0;
    status_word[ST_BUSY] = (seq != S_IDLE);
    status_word[ST_ACCUM] = (mode == M_ACCUM);
    status_word[ST_ERASING] = (mode == M_CHIP) || (mode == M_SECTOR) || (mode == M_SUSPENDING);
    status_word[ST_SUSPENDED] = (mode == M_SUSPENDED);
    status_word[ST_REFUSED] = refused;
    status_word[ST_TIMER_EXPIRED] = (mode == M_SECTOR) || (mode == M_SUSPENDING);
    status_word[ST_READY] = ready;
    status_word[ST_FLASH_RESET] = reset_ctrl;
    status_word[ST_ABORTED] = aborted;
    status_word[ST_PW_BUSY] = (mode == M_PW);
  end

  always_comb begin
    next_addr_reg = addr_reg;
    next_data_reg = data_reg;
    next_reset_ctrl = reset_ctrl;
    next_refused = refused;
    next_aborted = aborted;
    next_reg_rdata = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        REG_ADDR: next_addr_reg = reg_wdata[ADDR_W-1:0];
        REG_DATA: next_data_reg = reg_wdata[DATA_W-1:0];
        REG_RESET: next_reset_ctrl = reg_wdata[RESET_CTRL_BIT];
        REG_STATUS: begin
          next_refused = refused && !reg_wdata[ST_REFUSED];
          next_aborted = aborted && !reg_wdata[ST_ABORTED];
        end
        default: next_addr_reg = addr_reg;
      endcase
    end
    // A new event beats a clear written in the same cycle.
    if (refuse_pulse) begin
      next_refused = 1'b1;
    end
    if (abort_pulse) begin
      next_aborted = 1'b1;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CMD: next_reg_rdata = REG_DATA_W'(kind);
        REG_ADDR: next_reg_rdata = REG_DATA_W'(addr_reg);
        REG_DATA: next_reg_rdata = REG_DATA_W'(data_reg);
        REG_STATUS: next_reg_rdata = status_word;
        REG_RDATA: next_reg_rdata = REG_DATA_W'(read_word);
        REG_RESET: next_reg_rdata = REG_DATA_W'(reset_ctrl);
        default: next_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_reg <= '0;
      data_reg <= '0;
      reset_ctrl <= 1'b0;
      refused <= 1'b0;
      aborted <= 1'b0;
      reg_rdata <= '0;
    end else begin
      addr_reg <= next_addr_reg;
      data_reg <= next_data_reg;
      reset_ctrl <= next_reset_ctrl;
      refused <= next_refused;
      aborted <= next_aborted;
      reg_rdata <= next_reg_rdata;
    end
  end

  AST_CHIP_LAST_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    eng_start && kind == OP_CHIP_ERASE && step == 3'h5 |-> eng_data == CMD_CHIP_ERASE && eng_addr == UNLOCK_ADDR1)
    else $error("chip erase final write is wrong");
  AST_SECTOR_LAST_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    eng_start && kind == OP_SECTOR_ERASE && step == 3'h5 |-> eng_data == CMD_SECTOR_ERASE && eng_addr == cmd_addr)
    else $error("sector erase final write is wrong");
  AST_ADD_IN_WINDOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
    accept && op == OP_ADD_SECTOR |-> mode == M_ACCUM && 32'(timer) + 32'(ADD_GUARD_CYCLES) < 32'(ACCUM_CYCLES))
    else $error("added sector sent outside the window");
  AST_SUSPEND_LEGAL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    accept && op == OP_SUSPEND |-> mode == M_ACCUM || mode == M_SECTOR)
    else $error("suspend sent outside a sector erase");
  AST_RESUME_BANK: assert property (@(posedge sys_clk) disable iff (!reset_n)
    eng_start && kind == OP_RESUME |-> eng_addr == susp_bank && eng_data == CMD_RESUME && mode == M_SUSPENDED)
    else $error("resume not sent to the suspended bank");
  AST_PW_COMMAND: assert property (@(posedge sys_clk) disable iff (!reset_n)
    eng_start && kind == OP_PW_PROGRAM && step == 3'h2 |-> eng_data == CMD_PW_PROGRAM ##1 !eng_start [*2])
    else $error("password portion lacks its command");
  AST_PW_RESET_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mode == M_PW && seq == S_IDLE && next_seq == S_ISSUE && !reset_ctrl |=> kind == OP_RESET_CMD ##0 eng_start)
    else $error("no reset command after password programming");
  AST_WINDOW_CLOSED_BY_RESET: assert property (@(posedge sys_clk) disable iff (!reset_n)
    eng_done && kind == OP_RESET_CMD && mode == M_ACCUM && !reset_ctrl |=> mode == M_IDLE)
    else $error("window survives another command");
  AST_HW_RESET_ABORTS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(reset_ctrl) && mode == M_CHIP |=> mode == M_IDLE && aborted && !flash_reset_n)
    else $error("hardware reset did not abort the erase");
  AST_CHIP_REFUSES: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cmd_go && mode == M_CHIP && op != OP_READ |=> refused && kind == $past(kind))
    else $error("command accepted during chip erase");

endmodule

// file: rtl/flash_seq_pkg.sv
package flash_seq_pkg;

  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int REG_ADDR_W = 8;
  localparam int REG_DATA_W = 32;
  localparam int SYNC_STAGES = 2;
  localparam int TIMER_W = 16;
  localparam int COUNT_W = 8;

  localparam logic [REG_ADDR_W-1:0] REG_CMD = 8'h00;
  localparam logic [REG_ADDR_W-1:0] REG_ADDR = 8'h04;
  localparam logic [REG_ADDR_W-1:0] REG_DATA = 8'h08;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS = 8'h0C;
  localparam logic [REG_ADDR_W-1:0] REG_RDATA = 8'h10;
  localparam logic [REG_ADDR_W-1:0] REG_RESET = 8'h14;

  localparam int OPCODE_W = 4;
  localparam logic [OPCODE_W-1:0] OP_NONE = 4'h0;
  localparam logic [OPCODE_W-1:0] OP_CHIP_ERASE = 4'h1;
  localparam logic [OPCODE_W-1:0] OP_SECTOR_ERASE = 4'h2;
  localparam logic [OPCODE_W-1:0] OP_ADD_SECTOR = 4'h3;
  localparam logic [OPCODE_W-1:0] OP_SUSPEND = 4'h4;
  localparam logic [OPCODE_W-1:0] OP_RESUME = 4'h5;
  localparam logic [OPCODE_W-1:0] OP_RESET_CMD = 4'h6;
  localparam logic [OPCODE_W-1:0] OP_PW_PROGRAM = 4'h7;
  localparam logic [OPCODE_W-1:0] OP_READ = 4'h8;

  localparam int ST_BUSY = 0;
  localparam int ST_ACCUM = 1;
  localparam int ST_ERASING = 2;
  localparam int ST_SUSPENDED = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_TIMER_EXPIRED = 5;
  localparam int ST_READY = 6;
  localparam int ST_FLASH_RESET = 7;
  localparam int ST_ABORTED = 8;
  localparam int ST_PW_BUSY = 9;
  localparam int RESET_CTRL_BIT = 0;

  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 22'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 22'h0002AA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00AA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_SUSPEND = 16'h00B0;
  localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
  localparam logic [DATA_W-1:0] CMD_PW_PROGRAM = 16'h0038;

  localparam int CLOCK_MHZ = 250;
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int ACCUM_WINDOW_US = 80;
  localparam int ACCUM_WINDOW_CYCLES = ACCUM_WINDOW_US * CLOCK_MHZ;
  localparam int SUSPEND_MAX_US = 20;
  localparam int SUSPEND_MAX_CYCLES = SUSPEND_MAX_US * CLOCK_MHZ;
  localparam int WE_LOW_NS = 35;
  localparam int WE_LOW_CYCLES = (WE_LOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RD_ACCESS_NS = 80;
  localparam int RD_ACCESS_CYCLES = (RD_ACCESS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int BUSY_SETTLE_NS = 500;
  localparam int BUSY_SETTLE_CYCLES = (BUSY_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int ADD_GUARD_CYCLES = WE_LOW_CYCLES + 8;

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD} eng_state_t;
  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} seq_state_t;
  typedef enum logic [2:0] {M_IDLE, M_ACCUM, M_CHIP, M_SECTOR, M_SUSPENDING, M_SUSPENDED, M_PW} mode_t;

endpackage

// file: rtl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync
  import flash_seq_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] first_stage;

  // Each pin bit passes two flops; only the second stage is read by logic.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        first_stage[i] <= 1'b0;
        dout[i] <= 1'b0;
      end else begin
        first_stage[i] <= din[i];
        dout[i] <= first_stage[i];
      end
    end
  end

endmodule
